// file: design/ubt_uart.v
// Asynchronous serial port with baud generator, infrared codec and rx FIFO
//
// Contract
// - High-speed baud: clock over 4*(divisor+1)
// - Divisor write clears the baud timer
// - Transmit enable raises tx interrupt three cycles later
// - 8-bit byte loads shifter; starts next baud tick
// - Data queued while disabled starts on enable
// - Tx interrupt follows transmit interrupt mode
// - 9-bit mode: only word writes load nine bits
// - Break: dummy write starts break, value ignored
// - Break done clears request, sends next char
// - Receive enable at status bit 12
// - Rx interrupt per receive interrupt mode
// - Overrun flag stays until software clears
// - Rx data read pops FIFO with flags
// - Infrared modes only with 16x baud
// - Pin field 11 drives 16x clock on rts; rts held low in high-speed mode
// - Infrared enable routes pins through codec
// - Card protocol bit selects T0 or T1
// - Port enable hands pins to the port
// - Stop-in-idle halts module in Idle
// - Handshake bit: simplex or flow-control rts
// - Pin field selects which pins are used
// - Standard baud: clock over 16*(divisor+1)
// - High-speed: 4 ticks per bit, else 16
// - Parity/data field and stop bit select
// - Tx interrupt modes 00, 10, 01
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ubt_consts.vh"

module ubt_uart #(
	parameter RXQ_DEPTH = 4,
	parameter RXQ_AW    = 2
) (
	// Clock and reset
	input  wire        i_core_clk,
	input  wire        i_rst,
	// Register port
	input  wire [2:0]  i_addr,
	input  wire [15:0] i_wdata,
	input  wire [1:0]  i_wr_be,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [15:0] o_rdata,
	// System state
	input  wire        i_idle,
	// Line side
	input  wire        i_rx,
	input  wire        i_cts_n,
	output reg         o_tx,
	output reg         o_rts_n,
	output reg         o_tx_own,
	output reg         o_rx_own,
	output reg         o_rts_own,
	output reg         o_cts_own,
	// Events and card control
	output reg         o_tx_irq,
	output reg         o_rx_irq,
	output reg         o_card_t1
);

	function [15:0] ubt_merge;
		input [15:0] old_v;
		input [15:0] new_v;
		input [1:0]  be;
		begin
			ubt_merge = {be[1] ? new_v[15:8] : old_v[15:8],
				be[0] ? new_v[7:0] : old_v[7:0]};
		end
	endfunction

	reg  [15:0] mode_q;
	reg  [15:0] div_q;
	reg  [15:0] bcnt_q;
	reg  [1:0]  txim_q;
	reg  [1:0]  rxim_q;
	reg         rxen_q;
	reg         brk_q;
	reg         txen_q;
	reg         overrun_error_flag_q;
	reg         card_q;
	reg  [1:0]  txen_pipe_q;

	wire wr_mode = i_wr & (i_addr == `UBT_A_MODE);
	wire wr_stat = i_wr & (i_addr == `UBT_A_STAT);
	wire wr_txd  = i_wr & (i_addr == `UBT_A_TXDATA);
	wire wr_div  = i_wr & (i_addr == `UBT_A_DIVISOR);
	wire wr_card = i_wr & (i_addr == `UBT_A_CARD);
	wire rd_rxd  = i_rd & (i_addr == `UBT_A_RXDATA);

	wire [15:0] stat_w = ubt_merge({txim_q[1], 1'b0, txim_q[0], rxen_q,
		brk_q, txen_q, 2'b00, rxim_q, 6'h00}, i_wdata, i_wr_be);
	wire [1:0] pd    = mode_q[`UBT_M_PD_HI:`UBT_M_PD_LO];
	wire [1:0] pinen = mode_q[`UBT_M_PINEN_HI:`UBT_M_PINEN_LO];
	wire hs    = mode_q[`UBT_M_HSBAUD];
	wire ir_on = mode_q[`UBT_M_INFRARED_ENABLE] & ~hs;
	wire en    = mode_q[`UBT_M_PORT_EN];
	// Idle freeze keeps the bit counters and shifters where they stood; the baud timer is cleared
	wire run   = en & ~(mode_q[`UBT_M_SIDL] & i_idle);
	wire txen_rise = wr_stat & stat_w[`UBT_S_TXEN] & ~txen_q;
	wire txen_fall = wr_stat & ~stat_w[`UBT_S_TXEN] & txen_q;
	wire tick  = run & (bcnt_q == div_q);
	// 16 or 4 ticks per bit sets the overall divide by 16 or 4
	wire [3:0] os_last = hs ? `UBT_OS4_LAST : `UBT_OS16_LAST;

	// Baud timer; restarting it on enable lets queued data go at once
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			bcnt_q <= 16'h0000;
		else if (wr_div | txen_rise | ~run)
			bcnt_q <= 16'h0000;
		else if (tick)
			bcnt_q <= 16'h0000;
		else
			bcnt_q <= bcnt_q + 16'h0001;
	end

	// Software registers
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			mode_q <= `UBT_MODE_RST;
			div_q  <= `UBT_DIV_RST;
			txim_q <= 2'b00;
			rxim_q <= 2'b00;
			rxen_q <= 1'b0;
			txen_q <= 1'b0;
			card_q <= 1'b0;
			txen_pipe_q <= 2'b00;
		end
		else
		begin
			if (wr_mode)
				mode_q <= ubt_merge(mode_q, i_wdata, i_wr_be)
					& `UBT_MODE_WMASK;
			if (wr_div)
				div_q <= ubt_merge(div_q, i_wdata, i_wr_be);
			if (wr_card)
				card_q <= i_wr_be[0] ? i_wdata[0] : card_q;
			if (wr_stat)
			begin
				txim_q <= {stat_w[`UBT_S_TXIM1], stat_w[`UBT_S_TXIM0]};
				rxim_q <= stat_w[`UBT_S_RXIM_HI:`UBT_S_RXIM_LO];
				rxen_q <= stat_w[`UBT_S_RXEN];
				txen_q <= stat_w[`UBT_S_TXEN];
			end
			txen_pipe_q <= {txen_pipe_q[0], txen_rise};
		end
	end

	// Transmitter: one holding word ahead of the shifter
	reg  [8:0]  txbuf_q;
	reg         txbuf_full_q;
	reg         tx_busy_q;
	reg         tx_go_q;
	reg         tx_brkf_q;
	reg  [12:0] tx_sh_q;
	reg  [3:0]  tx_left_q;
	reg  [3:0]  tx_sub_q;
	reg         tx_ev_load;
	reg         tx_ev_done;

	wire nine = (pd == 2'b11);
	// A 9-bit character is only whole when both lanes are written
	wire tx_wr_ok = wr_txd & ~txbuf_full_q &
		(nine ? (i_wr_be == 2'b11) : i_wr_be[0]);
	wire cts_ok = (pinen != 2'b10) | ~i_cts_n;
	wire tx_start = txbuf_full_q & ~tx_busy_q & txen_q & run & cts_ok;
	wire tx_par = ^txbuf_q[7:0] ^ (pd == 2'b10);
	wire tx_last = tick & tx_go_q & (tx_sub_q == os_last) &
		(tx_left_q == 4'h1);

	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			txbuf_q      <= 9'h000;
			txbuf_full_q <= 1'b0;
			tx_busy_q    <= 1'b0;
			tx_go_q      <= 1'b0;
			tx_brkf_q    <= 1'b0;
			tx_sh_q      <= 13'h1FFF;
			tx_left_q    <= 4'h0;
			tx_sub_q     <= 4'h0;
			brk_q        <= 1'b0;
			tx_ev_load   <= 1'b0;
			tx_ev_done   <= 1'b0;
		end
		else
		begin
			tx_ev_load <= tx_start;
			tx_ev_done <= tx_last;
			if (wr_stat)
				brk_q <= stat_w[`UBT_S_BRK];
			else if (tx_last & tx_brkf_q)
				brk_q <= 1'b0;
			if (txen_fall)
			begin
				tx_busy_q    <= 1'b0;
				tx_go_q      <= 1'b0;
				txbuf_full_q <= 1'b0;
			end
			else if (tx_start)
			begin
				// Loaded at once; the line moves on the next tick
				tx_busy_q    <= 1'b1;
				tx_go_q      <= 1'b0;
				txbuf_full_q <= 1'b0;
				tx_brkf_q    <= brk_q;
				tx_sub_q     <= 4'h0;
				if (brk_q)
				begin
					// All thirteen low, the stop bit shifts in behind
					tx_sh_q   <= 13'h0000;
					tx_left_q <= `UBT_BRK_LEN;
				end
				else
				begin
					tx_left_q <= 4'hA + {3'b000, pd != 2'b00}
						+ {3'b000, mode_q[`UBT_M_STOP2]};
					if (nine)
						tx_sh_q <= {3'b111, txbuf_q, 1'b0};
					else if (pd == 2'b00)
						tx_sh_q <= {4'hF, txbuf_q[7:0], 1'b0};
					else
						tx_sh_q <= {3'b111, tx_par, txbuf_q[7:0], 1'b0};
				end
			end
			else if (tx_busy_q & tick)
			begin
				if (~tx_go_q)
					tx_go_q <= 1'b1;
				else if (tx_sub_q == os_last)
				begin
					tx_sub_q  <= 4'h0;
					tx_sh_q   <= {1'b1, tx_sh_q[12:1]};
					tx_left_q <= tx_left_q - 4'h1;
					if (tx_left_q == 4'h1)
					begin
						tx_busy_q <= 1'b0;
						tx_go_q   <= 1'b0;
					end
				end
				else
					tx_sub_q <= tx_sub_q + 4'h1;
			end
			if (tx_wr_ok)
			begin
				txbuf_q      <= nine ? i_wdata[8:0] : {1'b0, i_wdata[7:0]};
				txbuf_full_q <= 1'b1;
			end
		end
	end

	wire txd = (tx_busy_q & tx_go_q) ? tx_sh_q[0] : 1'b1;
	// Encoder sends a 3/16 bit pulse for each zero bit
	wire ir_txd = ~txd & (tx_sub_q < `UBT_IR_PULSE);

	// Receiver
	reg  [3:0]  ir_hold_q;
	reg         rx_busy_q;
	reg         rx_high_q;
	reg  [3:0]  rx_sub_q;
	reg  [3:0]  rx_cnt_q;
	reg  [11:0] rx_sh_q;
	reg  [10:0] rxq_mem [0:RXQ_DEPTH-1];
	reg  [RXQ_AW-1:0] rxq_wp_q;
	reg  [RXQ_AW-1:0] rxq_rp_q;
	reg  [RXQ_AW:0]   rxq_cnt_q;

	// Decoder stretches an incoming pulse into a low bit
	wire rx_line = ir_on ? ~(i_rx | (ir_hold_q != 4'h0)) : i_rx;
	wire [3:0] rx_n = 4'hA + {3'b000, pd != 2'b00};
	wire rx_smp = tick & rx_busy_q & (rx_sub_q == {1'b0, os_last[3:1]});
	wire rx_end = rx_smp & (rx_cnt_q == rx_n - 4'h1);
	wire [8:0] rx_dat = nine ? rx_sh_q[9:1] : {1'b0, rx_sh_q[8:1]};
	wire rx_parity_error_flag = (pd == 2'b01 || pd == 2'b10) &
		(^rx_sh_q[9:1] ^ (pd == 2'b10));
	wire rxq_full = (rxq_cnt_q == RXQ_DEPTH[RXQ_AW:0]);
	wire rxq_push = rx_end & ~rxq_full;
	wire rxq_pop  = rd_rxd & (rxq_cnt_q != {(RXQ_AW+1){1'b0}});
	wire overrun_error_flag_clr = wr_stat & i_wr_be[0] & ~i_wdata[`UBT_S_OVERRUN_ERROR_FLAG] & overrun_error_flag_q;
	wire [RXQ_AW:0] rxq_cnt_d = rxq_cnt_q
		+ {{RXQ_AW{1'b0}}, rxq_push} - {{RXQ_AW{1'b0}}, rxq_pop};
	wire [10:0] rxq_head = rxq_mem[rxq_rp_q];

	always @(posedge i_core_clk)
	begin
		if (rxq_push)
			rxq_mem[rxq_wp_q] <= {~rx_line, rx_parity_error_flag, rx_dat};
	end

	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ir_hold_q <= 4'h0;
			rx_high_q <= 1'b1;
			rx_busy_q <= 1'b0;
			rx_sub_q  <= 4'h0;
			rx_cnt_q  <= 4'h0;
			rx_sh_q   <= 12'h000;
			rxq_wp_q  <= {RXQ_AW{1'b0}};
			rxq_rp_q  <= {RXQ_AW{1'b0}};
			rxq_cnt_q <= {(RXQ_AW+1){1'b0}};
			overrun_error_flag_q    <= 1'b0;
		end
		else
		begin
			if (ir_on & i_rx)
				ir_hold_q <= `UBT_OS16_LAST;
			else if (tick & (ir_hold_q != 4'h0))
				ir_hold_q <= ir_hold_q - 4'h1;
			// Start needs a fall, so a low stop bit opens no new frame
			if (tick)
				rx_high_q <= rx_line;
			// Overflow sets even against a clearing write
			if (rx_end & rxq_full)
				overrun_error_flag_q <= 1'b1;
			else if (overrun_error_flag_clr)
				overrun_error_flag_q <= 1'b0;
			if (overrun_error_flag_clr | ~rxen_q)
			begin
				rx_busy_q <= 1'b0;
				rxq_wp_q  <= {RXQ_AW{1'b0}};
				rxq_rp_q  <= {RXQ_AW{1'b0}};
				rxq_cnt_q <= {(RXQ_AW+1){1'b0}};
			end
			else
			begin
				if (~rx_busy_q & tick & ~rx_line & rx_high_q)
				begin
					rx_busy_q <= 1'b1;
					rx_sub_q  <= 4'h1;
					rx_cnt_q  <= 4'h0;
				end
				else if (rx_busy_q & tick)
				begin
					rx_sub_q <= (rx_sub_q == os_last) ? 4'h0
						: rx_sub_q + 4'h1;
					if (rx_smp)
					begin
						rx_sh_q[rx_cnt_q] <= rx_line;
						rx_cnt_q <= rx_cnt_q + 4'h1;
						// A start that is high again at midbit is noise
						if ((rx_cnt_q == 4'h0 & rx_line) | rx_end)
							rx_busy_q <= 1'b0;
					end
				end
				if (rxq_push)
					rxq_wp_q <= rxq_wp_q + {{(RXQ_AW-1){1'b0}}, 1'b1};
				if (rxq_pop)
					rxq_rp_q <= rxq_rp_q + {{(RXQ_AW-1){1'b0}}, 1'b1};
				rxq_cnt_q <= rxq_cnt_d;
			end
		end
	end

	// Registered pins, events and read data
	wire [15:0] stat_r = {txim_q[1], 1'b0, txim_q[0], rxen_q, brk_q, txen_q,
		txbuf_full_q, ~(txbuf_full_q | tx_busy_q), rxim_q, 1'b0,
		~rx_busy_q, rxq_head[9], rxq_head[10], overrun_error_flag_q,
		rxq_cnt_q != {(RXQ_AW+1){1'b0}}};

	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_rdata   <= 16'h0000;
			o_tx      <= 1'b1;
			o_rts_n   <= 1'b1;
			o_tx_own  <= 1'b0;
			o_rx_own  <= 1'b0;
			o_rts_own <= 1'b0;
			o_cts_own <= 1'b0;
			o_tx_irq  <= 1'b0;
			o_rx_irq  <= 1'b0;
			o_card_t1 <= 1'b0;
		end
		else
		begin
			case (i_addr)
				`UBT_A_MODE:    o_rdata <= i_rd ? mode_q : 16'h0000;
				`UBT_A_STAT:    o_rdata <= i_rd ? stat_r : 16'h0000;
				`UBT_A_RXDATA:  o_rdata <= i_rd ?
					{7'h00, rxq_head[8:0]} : 16'h0000;
				`UBT_A_DIVISOR: o_rdata <= i_rd ? div_q : 16'h0000;
				`UBT_A_CARD:    o_rdata <= i_rd ? {15'h0000, card_q}
					: 16'h0000;
				default:        o_rdata <= 16'h0000;
			endcase
			o_tx      <= ir_on ? ir_txd : txd;
			o_tx_own  <= en & txen_q;
			o_rx_own  <= en & rxen_q;
			o_rts_own <= en & (pinen != 2'b00);
			o_cts_own <= en & (pinen == 2'b10);
			if (pinen == 2'b11)
				o_rts_n <= ~hs & (bcnt_q <= {1'b0, div_q[15:1]});
			else if (mode_q[`UBT_M_HSMODE])
				o_rts_n <= ~(tx_busy_q | txbuf_full_q);
			else
				o_rts_n <= ~(rxen_q & ~rxq_full);
			o_tx_irq  <= txen_pipe_q[1] |
				(tx_ev_load & ~txim_q[0]) |
				(tx_ev_done & (txim_q == 2'b01) & ~txbuf_full_q);
			o_rx_irq  <= rxq_push & ((rxim_q == 2'b11) ?
				(rxq_cnt_d == RXQ_DEPTH[RXQ_AW:0]) :
				(rxim_q == 2'b10) ? (rxq_cnt_d == 3) : 1'b1);
			o_card_t1 <= card_q;
		end
	end

endmodule // ubt_uart

// file: design/ubt_consts.vh
// Register map, field positions and reset values of the serial port
`ifndef UBT_CONSTS_VH
`define UBT_CONSTS_VH

// Register indices on the plain register port
`define UBT_A_MODE     3'h0
`define UBT_A_STAT     3'h1
`define UBT_A_TXDATA   3'h2
`define UBT_A_RXDATA   3'h3
`define UBT_A_DIVISOR  3'h4
`define UBT_A_CARD     3'h5

// serial_mode_control fields
`define UBT_M_PORT_EN  15
`define UBT_M_SIDL     13
`define UBT_M_INFRARED_ENABLE     12
`define UBT_M_HSMODE   11
`define UBT_M_PINEN_HI 9
`define UBT_M_PINEN_LO 8
`define UBT_M_HSBAUD   3
`define UBT_M_PD_HI    2
`define UBT_M_PD_LO    1
`define UBT_M_STOP2    0
`define UBT_MODE_WMASK 16'hBB0F

// serial_status_control fields
`define UBT_S_TXIM1    15
`define UBT_S_TXIM0    13
`define UBT_S_RXEN     12
`define UBT_S_BRK      11
`define UBT_S_TXEN     10
`define UBT_S_TXBF     9
`define UBT_S_TRMT     8
`define UBT_S_RXIM_HI  7
`define UBT_S_RXIM_LO  6
`define UBT_S_RIDLE    4
`define UBT_S_PARITY_ERROR_FLAG     3
`define UBT_S_FRAMING_ERROR_FLAG     2
`define UBT_S_OVERRUN_ERROR_FLAG     1
`define UBT_S_RXDA     0

// Reset values
`define UBT_MODE_RST   16'h0000
`define UBT_DIV_RST    16'h0000

// Timing counts: enable delay in core clock cycles, the rest in baud ticks or bits
`define UBT_TXEN_IRQ_DLY 2
`define UBT_IR_PULSE     4'h3
`define UBT_OS16_LAST    4'hF
`define UBT_OS4_LAST     4'h3
`define UBT_BRK_LEN      4'hE

`endif

// file: sim/ubt_uart_asserts.sv
// Port-level checks for the serial port, attached by bind
`timescale 1ns/1ps
`include "ubt_consts.vh"

module ubt_uart_asserts (
	// Clock and reset
	input wire        i_core_clk,
	input wire        i_rst,
	// Register port
	input wire [2:0]  i_addr,
	input wire [15:0] i_wdata,
	input wire [1:0]  i_wr_be,
	input wire        i_wr,
	input wire        i_rd,
	input wire [15:0] o_rdata,
	// Watched outputs
	input wire        o_tx,
	input wire        o_tx_irq,
	input wire        o_rx_irq,
	input wire        o_rts_own,
	input wire        o_cts_own,
	input wire        o_card_t1
);
	reg  [15:0] mode_q, div_q, run_q;
	reg  [2:0]  raddr_q;
	reg  [1:0]  stab_q;
	reg         rd_q, txen_q, ovr_q;
	wire        wr_m = i_wr && i_addr == `UBT_A_MODE;
	wire        wr_s = i_wr && i_addr == `UBT_A_STAT;
	wire        wr_d = i_wr && i_addr == `UBT_A_DIVISOR;
	wire        wr_c = i_wr && i_addr == `UBT_A_CARD && i_wr_be[0];
	wire [31:0] bitlen = (mode_q[3] ? 4 : 16) * (div_q + 32'd1);

	// Shadow of software-visible state kept from the bus traffic, plus the low run of o_tx
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			{mode_q, div_q, run_q, raddr_q} <= 51'h0;
			{stab_q, rd_q, txen_q, ovr_q} <= 5'h00;
		end
		else
		begin
			mode_q <= wr_m ? {i_wr_be[1] ? i_wdata[15:8] : mode_q[15:8],
				i_wr_be[0] ? i_wdata[7:0] : mode_q[7:0]} : mode_q;
			div_q <= wr_d ? i_wdata : div_q;
			txen_q <= (wr_s && i_wr_be[1]) ? i_wdata[10] : txen_q;
			stab_q <= wr_m ? 2'h0 : (stab_q == 2'h3 ? 2'h3 : stab_q + 2'h1);
			run_q <= o_tx ? 16'h0000 : run_q + 16'h0001;
			rd_q <= i_rd;
			raddr_q <= i_addr;
			ovr_q <= (wr_s && i_wr_be[0] && !i_wdata[1]) ? 1'b0 :
				(rd_q && raddr_q == `UBT_A_STAT && o_rdata[1]) ? 1'b1 : ovr_q;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence txen_set_s;
		wr_s && i_wr_be[1] && i_wdata[10] && !txen_q && mode_q[15];
	endsequence

	txen_irq_a: assert property (txen_set_s |-> ##3 o_tx_irq)
		else $error("no tx event after transmit enable");
	baud_width_a: assert property ($rose(o_tx) &&
		!mode_q[12] && run_q != 16'h0000 |-> run_q % bitlen == 0)
		else $error("low run not a whole number of bits");
	mode_read_a: assert property (rd_q &&
		raddr_q == `UBT_A_MODE |-> o_rdata == (mode_q & `UBT_MODE_WMASK))
		else $error("mode readback");
	pin_owner_a: assert property (stab_q == 2'h3 |->
		o_rts_own == (mode_q[15] && mode_q[9:8] != 2'b00) &&
		o_cts_own == (mode_q[15] && mode_q[9:8] == 2'b10))
		else $error("pin ownership wrong");
	card_sel_a: assert property ($past(wr_c, 2) |->
		o_card_t1 == $past(i_wdata[0], 2)) else $error("card protocol");
	rdata_idle_a: assert property (!rd_q |-> o_rdata == 16'h0000)
		else $error("read data outside read slot");
	ovr_sticky_a: assert property (rd_q &&
		raddr_q == `UBT_A_STAT && ovr_q |-> o_rdata[1])
		else $error("overrun flag dropped");
	rx_pulse_a: assert property (o_rx_irq |=> !o_rx_irq)
		else $error("rx event longer than one cycle");
endmodule // ubt_uart_asserts

// file: sim/ubt_peer.sv
// Remote serial peer: drives the receive line, decodes the transmit line
`timescale 1ns/1ps

module ubt_peer (
	// Clock
	input  wire i_clk,
	// Serial lines
	input  wire i_tx,
	output reg  o_rx
);
	initial o_rx = 1'b1;

	// Start, eight data bits LSB first, one stop, then two idle bits
	task automatic send(input [7:0] d, input bit stop, input int bl);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int k = 0; k < 12 * bl; k++)
		begin
			o_rx <= (k < 10 * bl) ? f[k / bl] : 1'b1;
			@(posedge i_clk);
		end
	endtask

	// Samples nine bit slots mid-bit and measures the first low run
	task automatic recv(input int bl, input int span,
		output logic [8:0] d, output int low);
		bit run;
		run = 1;
		low = 0;
		d = 9'h000;
		while (i_tx !== 1'b1) @(posedge i_clk);
		while (i_tx !== 1'b0) @(posedge i_clk);
		for (int n = 0; n < span; n++)
		begin
			if (run && i_tx === 1'b0) low++;
			else run = 0;
			if (n % bl == bl / 2 && n > bl && n < 10 * bl) d = {i_tx, d[8:1]};
			@(posedge i_clk);
		end
	endtask
endmodule // ubt_peer

// file: sim/testbench.sv
// Self-checking bench for the serial port against a remote peer model
`timescale 1ns/1ps
`include "ubt_consts.vh"
`define CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("wrong value t=%0t got %h want %h", $time, got, exp); \
		end \
	end

module testbench;
	reg          i_core_clk, i_rst, i_wr, i_rd, i_idle, i_cts_n;
	reg  [2:0]   i_addr;
	reg  [15:0]  i_wdata;
	reg  [1:0]   i_wr_be;
	wire [15:0]  o_rdata;
	wire         i_rx, o_tx, o_rts_n, o_tx_irq, o_rx_irq, o_card_t1;
	wire         o_tx_own, o_rx_own, o_rts_own, o_cts_own;
	int          fail_count, samples_checked, rx_irqs, low, bl;
	logic [15:0] r;
	logic [8:0]  d;
	logic [15:0] mcfg [4] = '{16'h8000, 16'h8008, 16'h8000, 16'h8006};
	logic [15:0] dcfg [4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000};

	ubt_uart dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr_be(i_wr_be), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_idle(i_idle), .i_rx(i_rx), .i_cts_n(i_cts_n),
		.o_tx(o_tx), .o_rts_n(o_rts_n), .o_tx_own(o_tx_own),
		.o_rx_own(o_rx_own), .o_rts_own(o_rts_own), .o_cts_own(o_cts_own),
		.o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq), .o_card_t1(o_card_t1));
	ubt_peer peer (.i_clk(i_core_clk), .i_tx(o_tx), .o_rx(i_rx));

	initial
	begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end

	always @(posedge i_core_clk) if (o_rx_irq === 1'b1) rx_irqs++;

	task wr(input [2:0] a, input [15:0] v, input [1:0] be);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr_be <= be;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	task rd(input [2:0] a, output [15:0] v);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Whole run needs some 2500 cycles; sixteen times that means a hang
	initial
	begin
		repeat (40000) @(posedge i_core_clk);
		fail_count++;
		finish_test;
	end

	initial
	begin
		{i_rst, i_wr, i_rd, i_idle, i_cts_n, i_addr} = 8'h80;
		{i_wdata, i_wr_be} = 18'h00000;
		{fail_count, samples_checked, rx_irqs} = 0;
		repeat (16) @(posedge i_core_clk);
		i_rst <= 1'b0;
		rd(`UBT_A_MODE, r);
		`CHK(r, `UBT_MODE_RST)
		rd(3'h6, r);
		`CHK(r, 16'h0000)
		wr(`UBT_A_MODE, 16'hABF7, 2'b11);
		rd(`UBT_A_MODE, r);
		`CHK(r, 16'hAB07)
		for (int c = 1; c >= 0; c--)
		begin
			wr(`UBT_A_CARD, c, 2'b01);
			repeat (2) @(posedge i_core_clk);
			#1 `CHK(o_card_t1, c[0])
		end
		$display("test registers done");
		// Data queued with the transmitter off, then enabled
		for (int i = 0; i < 4; i++)
		begin
			bl = (mcfg[i][3] ? 4 : 16) * (dcfg[i] + 1);
			wr(`UBT_A_STAT, 16'h0000, 2'b11);
			wr(`UBT_A_DIVISOR, dcfg[i], 2'b11);
			wr(`UBT_A_MODE, mcfg[i], 2'b11);
			wr(`UBT_A_TXDATA, 16'h0033, i == 3 ? 2'b01 : 2'b00);
			wr(`UBT_A_TXDATA, i == 3 ? 16'h01A5 : 16'h0041, 2'b11);
			wr(`UBT_A_STAT, 16'h0400, 2'b10);
			peer.recv(bl, 10 * bl, d, low);
			`CHK(d, i == 3 ? 9'h1A5 : 9'h141)
			`CHK(low, bl)
		end
		$display("test transmit done");
		wr(`UBT_A_MODE, 16'h8000, 2'b11);
		wr(`UBT_A_STAT, 16'h0C00, 2'b10);
		wr(`UBT_A_TXDATA, 16'h00FF, 2'b01);
		peer.recv(16, 13 * 16 + 8, d, low);
		`CHK(low, 13 * 16)
		wr(`UBT_A_TXDATA, 16'h0055, 2'b01);
		peer.recv(16, 160, d, low);
		`CHK(d, 9'h155)
		rd(`UBT_A_STAT, r);
		`CHK(r[11], 1'b0)
		$display("test break done");
		// Clear-to-send held off, then an idle halt: the word stays queued
		@(posedge i_core_clk);
		i_cts_n <= 1'b1;
		wr(`UBT_A_MODE, 16'hA200, 2'b11);
		wr(`UBT_A_TXDATA, 16'h0041, 2'b01);
		repeat (40) @(posedge i_core_clk);
		i_idle <= 1'b1;
		i_cts_n <= 1'b0;
		repeat (40) @(posedge i_core_clk);
		rd(`UBT_A_STAT, r);
		`CHK(r[9:8], 2'b10)
		`CHK(o_tx, 1'b1)
		@(posedge i_core_clk);
		i_idle <= 1'b0;
		peer.recv(16, 160, d, low);
		`CHK(d, 9'h141)
		`CHK(low, 16)
		$display("test hold-off done");
		wr(`UBT_A_STAT, 16'h1000, 2'b11);
		rx_irqs = 0;
		for (int k = 0; k < 5; k++) peer.send(8'hA0 + k, k != 1, 16);
		#1 `CHK(rx_irqs, 4)
		`CHK({o_tx_own, o_rx_own, o_rts_n}, 3'b011)
		for (int k = 0; k < 4; k++)
		begin
			rd(`UBT_A_STAT, r);
			`CHK(r[2:0], {k == 1, 2'b11})
			rd(`UBT_A_RXDATA, r);
			`CHK(r, 16'h00A0 + k)
		end
		wr(`UBT_A_STAT, 16'h1000, 2'b01);
		rd(`UBT_A_STAT, r);
		`CHK(r[1:0], 2'b00)
		`CHK(o_rts_n, 1'b0)
		$display("test receive done");
		finish_test;
	end
endmodule // testbench

bind ubt_uart ubt_uart_asserts u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr_be(i_wr_be), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_tx(o_tx), .o_tx_irq(o_tx_irq),
	.o_rx_irq(o_rx_irq), .o_rts_own(o_rts_own), .o_cts_own(o_cts_own),
	.o_card_t1(o_card_t1));
